//--- pkg/tdm_rx_regs.svh
// register offsets, field positions, reset values and timing counts of the receive port
// assumes a 10 MHz core clock; included by bare name
`ifndef TDM_RX_REGS_SVH
`define TDM_RX_REGS_SVH
`define CFG_ADDR          8'h00
`define STATUS_ADDR       8'h04
`define SAMPLE_ADDR       8'h08
`define CFG_RESET         32'h0000_1400
`define CFG_DETECT_DIS    0
`define CFG_FRAME_POL     1
`define CFG_RX_EDGE       2
`define CFG_JUSTIFY       3
`define CFG_OFFSET_LSB    4
`define CFG_SLEN_LSB      9
`define CFG_WLEN_LSB      11
`define CFG_SRC_LSB       13
`define CFG_SLOT_L_LSB    15
`define CFG_SLOT_R_LSB    19
`define CFG_MRATE_LSB     23
`define CFG_MRATIO_LSB    26
`define RATE_44K1         3'h0
`define RATE_48K          3'h1
`define RATE_88K2         3'h2
`define RATE_96K          3'h3
`define RATE_NONE         3'h7
`define RATIO_NONE        4'hF
`define CORE_CLK_HZ       10000000
`define FS_44K1_HZ        44100
`define FS_48K_HZ         48000
`define FS_88K2_HZ        88200
`define FS_96K_HZ         96000
`define FS_TOL            12'd6
`define FS_CYC(hz)        (12'((`CORE_CLK_HZ + (hz) / 2) / (hz)))
`define FRAME_TMO         12'd400
`define RAMP_DIV          8'd16
`define GAIN_FULL         8'hFF
`endif

//--- pkg/tdm_rx_pkg.sv
// types shared by the receive port and its slot capture units
package tdm_rx_pkg;
   typedef enum logic [1:0] {SRC_STRAP, SRC_LEFT, SRC_RIGHT, SRC_MIX} source_e;
   typedef logic [31:0] word_t;
endpackage

//--- pkg/slot_bus_if.sv
// bit stream shared by the frame tracker and the slot capture units
// all signals are on the core clock
`timescale 1ns/1ns
interface slot_bus_if;
   logic       bit_stb;
   logic       bit_val;
   logic [4:0] slot_num;
   logic [5:0] slot_bit;
   logic       frame_stb;
   logic [5:0] slen;
   logic [5:0] wlen;
   logic       justify;
   modport tracker (output bit_stb, bit_val, slot_num, slot_bit, frame_stb, slen, wlen, justify);
   modport capture (input bit_stb, bit_val, slot_num, slot_bit, frame_stb, slen, wlen, justify);
endinterface

//--- rtl/slot_capture.sv
// captures the audio word of one selected slot from the bit stream
// assumes the stream strobes at most once per core clock cycle
`timescale 1ns/1ns
module slot_capture (
   // clock and reset
   input  wire logic              CORE_CLK,
   input  wire logic              RESETN,
   // stream and selection
   slot_bus_if.capture            sb,
   input  wire logic [3:0]        target,
   // captured word
   output tdm_rx_pkg::word_t      word_q,
   output logic                   have_q
);
   import tdm_rx_pkg::*;
   logic [5:0] first;
   logic [5:0] nbits;
   logic       take;
   logic       done;
   logic [31:0] shift_q;
   logic [5:0]  taken_q;
   logic [31:0] shift_d;

   // a word wider than the slot is cut to the slot
   assign nbits = (sb.wlen > sb.slen) ? sb.slen : sb.wlen;
   assign first = sb.justify ? 6'(sb.slen - nbits) : 6'h00;
   assign take  = sb.bit_stb && ({1'b0, target} == sb.slot_num)
                  && (sb.slot_bit >= first) && (sb.slot_bit < 6'(first + nbits));
   assign done  = sb.bit_stb && ({1'b0, target} == sb.slot_num)
                  && (sb.slot_bit == 6'(sb.slen - 6'h01));
   assign shift_d = take ? {shift_q[30:0], sb.bit_val} : shift_q;

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         shift_q <= 32'h0000_0000;
         taken_q <= 6'h00;
      end else if (sb.frame_stb && !take) begin
         shift_q <= 32'h0000_0000;
         taken_q <= 6'h00;
      end else if (take) begin
         shift_q <= shift_d;
         taken_q <= 6'(taken_q + 6'h01);
      end
   end

   // word lands msb-aligned in 32 bits
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         word_q <= 32'h0000_0000;
         have_q <= 1'b0;
      end else if (done) begin
         word_q <= shift_d << 6'(6'd32 - nbits);
         have_q <= 1'b1;
      end else if (sb.frame_stb) begin
         have_q <= 1'b0;
      end
   end

   AST_DONE_HAS_WORD: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      done |=> have_q && (word_q == $past(shift_d) << 6'(6'd32 - $past(nbits))))
      else $error("completed slot not latched");
endmodule // slot_capture

//--- rtl/tdm_rx_port.sv
// receive side of a multi-slot serial audio port, with clock checking and volume ramp
// assumes: frame sync, bit clock and data arrive asynchronously on pins; bit clock is
// well below half the core clock; registers are reached over a plain strobe port
`timescale 1ns/1ns
`include "tdm_rx_regs.svh"
module tdm_rx_port (
   // clock and reset
   input  wire logic              CORE_CLK,
   input  wire logic              RESETN,
   // serial audio pins and address strap
   input  wire logic              FRAME_SYNC,
   input  wire logic              SERIAL_BIT_CLOCK,
   input  wire logic              SERIAL_DATA_IN,
   input  wire logic [2:0]        ADDR_STRAP,
   // register port
   input  wire logic [7:0]        REG_ADDR,
   input  wire logic [31:0]       REG_WDATA,
   input  wire logic              REG_WR,
   input  wire logic              REG_RD,
   output logic [31:0]            REG_RDATA,
   // playback path
   output tdm_rx_pkg::word_t      PLAYBACK_SAMPLE,
   output logic                   PLAYBACK_VALID,
   output logic                   CLOCK_FAULT
);
   import tdm_rx_pkg::*;
   slot_bus_if sb ();

   logic [2:0]  fs_sync_q, bclk_sync_q, serial_data_in_sync_q, strap_s1_q, strap_s2_q;
   logic        bclk_d3_q;
   logic [31:0] cfg_q;
   logic [3:0]  strap_q;
   logic [1:0]  strap_wait_q;
   logic        strap_taken_q;
   logic        edge_stb, fs_now, fs_prev_q, fs_edge;
   logic [9:0]  bit_cnt_q, cur_cnt;
   logic [9:0]  pos;
   logic        in_frame;
   logic [5:0]  sb_q, sb_cur;
   logic [4:0]  sn_q, sn_cur;
   logic [4:0]  offset;
   logic [11:0] per_cnt_q;
   logic        seen_q;
   logic [2:0]  rate_q;
   logic [3:0]  ratio_q;
   logic [4:0]  slot_cnt_q;
   logic        fault;
   logic [7:0]  gain_q;
   logic [7:0]  ramp_div_q;
   logic        ramp_en;
   source_e     src;
   logic [3:0]  tgt_l;
   word_t       word_l, word_r;
   logic        have_l, have_r;
   logic [32:0] mix_sum;
   word_t       raw;
   logic [40:0] scaled;
   word_t       last_q;

   // three flops on each serial pin; the bit clock gets a fourth as edge reference
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         fs_sync_q   <= 3'h0;
         bclk_sync_q <= 3'h0;
         serial_data_in_sync_q <= 3'h0;
         bclk_d3_q   <= 1'b0;
      end else begin
         fs_sync_q   <= {fs_sync_q[1:0], FRAME_SYNC};
         bclk_sync_q <= {bclk_sync_q[1:0], SERIAL_BIT_CLOCK};
         serial_data_in_sync_q <= {serial_data_in_sync_q[1:0], SERIAL_DATA_IN};
         bclk_d3_q   <= bclk_sync_q[2];
      end
   end

   // strap caught once its synchroniser has settled after reset release
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         strap_s1_q    <= 3'h0;
         strap_s2_q    <= 3'h0;
         strap_q       <= 4'h0;
         strap_wait_q  <= 2'h0;
         strap_taken_q <= 1'b0;
      end else begin
         strap_s1_q <= ADDR_STRAP;
         strap_s2_q <= strap_s1_q;
         if (!strap_taken_q) begin
            strap_wait_q <= 2'(strap_wait_q + 2'h1);
            if (strap_wait_q == 2'h3) begin
               strap_q       <= {1'b0, strap_s2_q};
               strap_taken_q <= 1'b1;
            end
         end
      end
   end

   // configuration register
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cfg_q <= `CFG_RESET;
      end else if (REG_WR && REG_ADDR == `CFG_ADDR) begin
         cfg_q <= {2'h0, REG_WDATA[29:0]};
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         REG_RDATA <= 32'h0000_0000;
      end else if (REG_RD) begin
         unique case (REG_ADDR)
            `CFG_ADDR:    REG_RDATA <= cfg_q;
            `STATUS_ADDR: REG_RDATA <= {11'h000, gain_q, fault, slot_cnt_q,
                                        ratio_q, rate_q};
            `SAMPLE_ADDR: REG_RDATA <= last_q;
            default:      REG_RDATA <= 32'h0000_0000;
         endcase
      end else begin
         REG_RDATA <= 32'h0000_0000;
      end
   end

   // bit stream framing
   assign edge_stb = cfg_q[`CFG_RX_EDGE] ? (~bclk_sync_q[2] & bclk_d3_q)
                                         : (bclk_sync_q[2] & ~bclk_d3_q);
   assign fs_now   = fs_sync_q[2];
   assign fs_edge  = edge_stb && (cfg_q[`CFG_FRAME_POL] ? (fs_now & ~fs_prev_q)
                                                        : (~fs_now & fs_prev_q));
   assign offset   = cfg_q[`CFG_OFFSET_LSB +: 5];
   assign cur_cnt  = fs_edge ? 10'h000 : 10'(bit_cnt_q + 10'h001);
   assign in_frame = seen_q || fs_edge;
   assign pos      = 10'(cur_cnt - {5'h00, offset});

   always_comb begin
      unique case (cfg_q[`CFG_SLEN_LSB +: 2])
         2'h0:    sb.slen = 6'd16;
         2'h1:    sb.slen = 6'd24;
         default: sb.slen = 6'd32;
      endcase
      unique case (cfg_q[`CFG_WLEN_LSB +: 2])
         2'h0:    sb.wlen = 6'd16;
         2'h1:    sb.wlen = 6'd20;
         2'h2:    sb.wlen = 6'd24;
         default: sb.wlen = 6'd32;
      endcase
   end

   always_comb begin
      sb_cur = sb_q;
      sn_cur = sn_q;
      if (pos == 10'h000) begin
         sb_cur = 6'h00;
         sn_cur = 5'h00;
      end else if (sb_q == 6'(sb.slen - 6'h01)) begin
         sb_cur = 6'h00;
         sn_cur = (sn_q == 5'h1F) ? sn_q : 5'(sn_q + 5'h01);
      end else begin
         sb_cur = 6'(sb_q + 6'h01);
      end
   end

   assign sb.bit_stb   = edge_stb && in_frame && (cur_cnt >= {5'h00, offset});
   assign sb.bit_val   = serial_data_in_sync_q[2];
   assign sb.slot_num  = sn_cur;
   assign sb.slot_bit  = sb_cur;
   assign sb.frame_stb = fs_edge;
   assign sb.justify   = cfg_q[`CFG_JUSTIFY];

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         fs_prev_q <= 1'b0;
         bit_cnt_q <= 10'h000;
         sb_q      <= 6'h00;
         sn_q      <= 5'h1F;
      end else if (edge_stb) begin
         fs_prev_q <= fs_now;
         bit_cnt_q <= (cur_cnt == 10'h3FF) ? bit_cnt_q : cur_cnt;
         if (fs_edge) begin
            sn_q <= 5'h1F;
         end
         if (sb.bit_stb) begin
            sb_q <= sb_cur;
            sn_q <= sn_cur;
         end
      end
   end

   // measures each frame in bit clocks and core cycles, so no slot count is programmed
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         per_cnt_q  <= 12'h000;
         seen_q     <= 1'b0;
         rate_q     <= `RATE_NONE;
         ratio_q    <= `RATIO_NONE;
         slot_cnt_q <= 5'h00;
      end else if (fs_edge) begin
         per_cnt_q <= 12'h000;
         seen_q    <= 1'b1;
         if (seen_q) begin
            rate_q     <= rate_of(per_cnt_q);
            ratio_q    <= ratio_of(10'(bit_cnt_q + 10'h001));
            slot_cnt_q <= (sn_q == 5'h1F) ? 5'h00
                        : 5'(sn_q + ((sb_q == 6'(sb.slen - 6'h01)) ? 5'h01 : 5'h00));
         end
      end else if (per_cnt_q == `FRAME_TMO) begin
         seen_q <= 1'b0;
         rate_q <= `RATE_NONE;
      end else begin
         per_cnt_q <= 12'(per_cnt_q + 12'h001);
      end
   end

   function automatic logic [2:0] rate_of(input logic [11:0] cyc);
      logic [2:0] r;
      r = `RATE_NONE;
      if (near(cyc, `FS_CYC(`FS_44K1_HZ))) r = `RATE_44K1;
      if (near(cyc, `FS_CYC(`FS_48K_HZ)))  r = `RATE_48K;
      if (near(cyc, `FS_CYC(`FS_88K2_HZ))) r = `RATE_88K2;
      if (near(cyc, `FS_CYC(`FS_96K_HZ)))  r = `RATE_96K;
      return r;
   endfunction

   function automatic logic near(input logic [11:0] a, input logic [11:0] b);
      return (a + `FS_TOL >= b) && (a <= b + `FS_TOL);
   endfunction

   function automatic logic [3:0] ratio_of(input logic [9:0] n);
      unique case (n)
         10'd16:  return 4'h0;
         10'd24:  return 4'h1;
         10'd32:  return 4'h2;
         10'd48:  return 4'h3;
         10'd64:  return 4'h4;
         10'd96:  return 4'h5;
         10'd128: return 4'h6;
         10'd192: return 4'h7;
         10'd256: return 4'h8;
         10'd512: return 4'h9;
         10'd125: return 4'hA;
         10'd250: return 4'hB;
         default: return `RATIO_NONE;
      endcase
   endfunction

   // fast rates carry half the bit budget, so more than 8 slots there is a fault
   assign fault = !seen_q || (ratio_q == `RATIO_NONE) || (rate_q == `RATE_NONE)
                  || ((rate_q == `RATE_88K2 || rate_q == `RATE_96K) && slot_cnt_q > 5'd8)
                  || (cfg_q[`CFG_DETECT_DIS] && (rate_q != cfg_q[`CFG_MRATE_LSB +: 3]
                      || ratio_q != cfg_q[`CFG_MRATIO_LSB +: 4]));
   assign CLOCK_FAULT = fault;

   // gain steps one count per divider pulse instead of dropping to silence
   assign ramp_en = (ramp_div_q == 8'(`RAMP_DIV - 8'd1));
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ramp_div_q <= 8'h00;
         gain_q     <= 8'h00;
      end else begin
         ramp_div_q <= ramp_en ? 8'h00 : 8'(ramp_div_q + 8'h01);
         if (ramp_en && fault && gain_q != 8'h00) begin
            gain_q <= 8'(gain_q - 8'h01);
         end else if (ramp_en && !fault && gain_q != `GAIN_FULL) begin
            gain_q <= 8'(gain_q + 8'h01);
         end
      end
   end

   // slot selection and extraction
   assign src   = source_e'(cfg_q[`CFG_SRC_LSB +: 2]);
   assign tgt_l = (src == SRC_STRAP) ? strap_q : cfg_q[`CFG_SLOT_L_LSB +: 4];

   slot_capture cap_left (
      .CORE_CLK (CORE_CLK),
      .RESETN   (RESETN),
      .sb       (sb),
      .target   (tgt_l),
      .word_q   (word_l),
      .have_q   (have_l)
   );

   slot_capture cap_right (
      .CORE_CLK (CORE_CLK),
      .RESETN   (RESETN),
      .sb       (sb),
      .target   (cfg_q[`CFG_SLOT_R_LSB +: 4]),
      .word_q   (word_r),
      .have_q   (have_r)
   );

   // a slot that never completed in the frame plays as digital silence
   assign mix_sum = {word_l[31], word_l} + {word_r[31], word_r};
   always_comb begin
      unique case (src)
         SRC_RIGHT: raw = have_r ? word_r : 32'h0000_0000;
         SRC_MIX:   raw = (have_l && have_r) ? mix_sum[32:1] : 32'h0000_0000;
         default:   raw = have_l ? word_l : 32'h0000_0000;
      endcase
   end
   assign scaled = 41'($signed(raw) * $signed({1'b0, gain_q}));

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         PLAYBACK_SAMPLE <= 32'h0000_0000;
         PLAYBACK_VALID  <= 1'b0;
         last_q          <= 32'h0000_0000;
      end else begin
         PLAYBACK_VALID <= fs_edge && seen_q;
         if (fs_edge && seen_q) begin
            PLAYBACK_SAMPLE <= scaled[39:8];
            last_q          <= raw;
         end
      end
   end

   AST_VALID_ON_FRAME: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      PLAYBACK_VALID |-> $past(fs_edge) && $past(seen_q))
      else $error("sample delivered without frame start");
   AST_RAMP_DOWN: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      ramp_en && fault && gain_q != 8'h00 |=> gain_q == $past(gain_q) - 8'h01)
      else $error("gain did not ramp down on fault");
   AST_RAMP_UP: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      ramp_en && !fault && gain_q != 8'hFF |=> gain_q == $past(gain_q) + 8'h01)
      else $error("gain did not ramp up on good clocks");
   AST_MANUAL_MISMATCH: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      cfg_q[0] && rate_q != cfg_q[25:23] |-> CLOCK_FAULT)
      else $error("manual rate mismatch not flagged");
   AST_BAD_RATIO: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      fs_edge && seen_q && ratio_of(10'(bit_cnt_q + 10'h001)) == 4'hF |=> CLOCK_FAULT)
      else $error("unsupported ratio not flagged");
   AST_NULL_SLOT: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      PLAYBACK_VALID && $past(src) == SRC_LEFT && !$past(have_l)
      |-> PLAYBACK_SAMPLE == 32'h0000_0000)
      else $error("missing slot not muted");
   AST_STRAP_SLOT: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      $rose(strap_taken_q) |-> strap_q == {1'b0, $past(strap_s2_q)}
      && (src != SRC_STRAP || tgt_l == {1'b0, $past(strap_s2_q)}))
      else $error("default slot differs from strap");
   AST_SLOT_COUNT: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
      fs_edge && seen_q && sn_q == 5'h02 && sb_q == 6'(sb.slen - 6'h01)
      |=> slot_cnt_q == 5'h03)
      else $error("slot count not measured");
endmodule // tdm_rx_port

//--- dv/tdm_host_model.sv
// host side of the serial audio link: bit clock, frame sync and slot data
// assumes the bench sets the frame shape at time zero and the clock half period in ns
`timescale 1ns/1ns
module tdm_host_model (
   // frame shape
   input  wire logic [15:0]       half_ns,
   input  wire logic [4:0]        nslots,
   input  wire logic [1:0]        slen_code,
   input  wire logic [4:0]        offset,
   input  wire logic              frame_pol,
   input  wire logic              rx_edge,
   input  wire logic [15:0][31:0] slots,
   // serial pins
   output logic                   frame_sync,
   output logic                   serial_bit_clock,
   output logic                   serial_data_in
);
   int slen;
   int nbits;
   int b;

   initial begin
      frame_sync       = 1'h1;
      serial_bit_clock = 1'h0;
      serial_data_in   = 1'h0;
      #1;
      forever begin
         slen  = 16 + 8 * int'(slen_code);
         // whole slots only, so each frame is slen times nslots bit clocks
         nbits = slen * int'(nslots);
         for (int k = 0; k < nbits; k++) begin
            #(half_ns);
            // launch on the edge opposite the sampling one, so setup and hold are both half
            serial_bit_clock = rx_edge;
            frame_sync = (k == 0) ? frame_pol : ~frame_pol;
            b = k - int'(offset);
            if (b >= 0) begin
               serial_data_in = slots[b / slen][31 - (b % slen)];
            end
            else begin
               // no slot bit here: a changing level, never a stale one
               serial_data_in = ~serial_data_in;
            end
            #(half_ns);
            serial_bit_clock = ~rx_edge;
         end
      end
   end
endmodule // tdm_host_model

//--- dv/tdm_audio_receive_port_bench.sv
// self-checking bench of the receive port with a host model on the serial pins
// assumes a 100 ns core clock; registers read and written over the strobe port
`timescale 1ns/1ns
`include "tdm_rx_regs.svh"
module tdm_audio_receive_port_bench;
   import tdm_rx_pkg::*;

   typedef struct packed {
      logic       pol;
      logic       edg;
      logic       just;
      logic [4:0] off;
      logic [1:0] slen;
      logic [1:0] wlen;
      logic [1:0] src;
      logic [3:0] sl;
      logic [3:0] sr;
      logic [4:0] nsl;
   } row_s;

   logic              CORE_CLK;
   logic              RESETN;
   logic [2:0]        ADDR_STRAP;
   logic [7:0]        REG_ADDR;
   logic [31:0]       REG_WDATA;
   logic              REG_WR;
   logic              REG_RD;
   wire logic [31:0]  REG_RDATA;
   word_t             PLAYBACK_SAMPLE;
   logic              PLAYBACK_VALID;
   logic              CLOCK_FAULT;
   wire logic         FRAME_SYNC;
   wire logic         SERIAL_BIT_CLOCK;
   wire logic         SERIAL_DATA_IN;
   logic [15:0]       half_ns = 16'h0190;
   logic [4:0]        nslots = 5'h03;
   logic [1:0]        slen_code = 2'h0;
   logic [4:0]        offset = 5'h00;
   logic              frame_pol = 1'h0;
   logic              rx_edge = 1'h0;
   logic [15:0][31:0] slots;
   int                miscompares = 0;
   int                samples_checked = 0;
   logic [31:0]       got;

   // pol edg just off slen wlen src sl sr nsl; the link runs at 800 ns here
   row_s rows [10] = '{
      '{1'h0, 1'h0, 1'h0, 5'h00, 2'h0, 2'h0, 2'h0, 4'h0, 4'h0, 5'h03},
      '{1'h1, 1'h1, 1'h0, 5'h01, 2'h1, 2'h0, 2'h1, 4'h0, 4'h0, 5'h02},
      '{1'h0, 1'h1, 1'h1, 5'h00, 2'h1, 2'h1, 2'h2, 4'h0, 4'h1, 5'h02},
      '{1'h1, 1'h0, 1'h0, 5'h01, 2'h2, 2'h3, 2'h1, 4'h0, 4'h0, 5'h01},
      '{1'h0, 1'h0, 1'h0, 5'h00, 2'h0, 2'h0, 2'h3, 4'h0, 4'h2, 5'h03},
      '{1'h0, 1'h0, 1'h0, 5'h1F, 2'h0, 2'h0, 2'h1, 4'h0, 4'h0, 5'h03},
      '{1'h0, 1'h0, 1'h0, 5'h1F, 2'h0, 2'h0, 2'h1, 4'h2, 4'h0, 5'h03},
      '{1'h0, 1'h0, 1'h1, 5'h00, 2'h2, 2'h2, 2'h2, 4'h0, 4'h0, 5'h01},
      '{1'h0, 1'h0, 1'h0, 5'h00, 2'h2, 2'h3, 2'h1, 4'h0, 4'h0, 5'h01},
      '{1'h0, 1'h0, 1'h0, 5'h00, 2'h2, 2'h2, 2'h1, 4'h5, 4'h0, 5'h01}};
   // two 16-bit slots at 650 ns: 208 core cycles a frame, a valid 48 kHz clock
   row_s fast_r = '{1'h0, 1'h0, 1'h0, 5'h00, 2'h0, 2'h0, 2'h1, 4'h0, 4'h0, 5'h02};

   tdm_rx_port dut_u (
      .CORE_CLK         (CORE_CLK),
      .RESETN           (RESETN),
      .FRAME_SYNC       (FRAME_SYNC),
      .SERIAL_BIT_CLOCK (SERIAL_BIT_CLOCK),
      .SERIAL_DATA_IN   (SERIAL_DATA_IN),
      .ADDR_STRAP       (ADDR_STRAP),
      .REG_ADDR         (REG_ADDR),
      .REG_WDATA        (REG_WDATA),
      .REG_WR           (REG_WR),
      .REG_RD           (REG_RD),
      .REG_RDATA        (REG_RDATA),
      .PLAYBACK_SAMPLE  (PLAYBACK_SAMPLE),
      .PLAYBACK_VALID   (PLAYBACK_VALID),
      .CLOCK_FAULT      (CLOCK_FAULT)
   );

   tdm_host_model host_u (
      .half_ns          (half_ns),
      .nslots           (nslots),
      .slen_code        (slen_code),
      .offset           (offset),
      .frame_pol        (frame_pol),
      .rx_edge          (rx_edge),
      .slots            (slots),
      .frame_sync       (FRAME_SYNC),
      .serial_bit_clock (SERIAL_BIT_CLOCK),
      .serial_data_in   (SERIAL_DATA_IN)
   );

   function automatic logic [31:0] slotv(input int s);
      return 32'hC35A_96E1 + 32'(s) * 32'h1357_9BDF;
   endfunction

   function automatic logic [31:0] cfg(input row_s r, input logic dis, input logic [2:0] rate,
                                       input logic [3:0] ratio);
      return {2'h0, ratio, rate, r.sr, r.sl, r.src, r.wlen, r.slen, r.off, r.just, r.edg,
              r.pol, dis};
   endfunction

   // msb-aligned word of a slot, or mute when the slot runs past the frame end
   function automatic logic [31:0] word_of(input logic [3:0] s, input row_s r);
      int          sl;
      int          wl;
      logic [31:0] m;
      sl = 16 + 8 * int'(r.slen);
      wl = (r.wlen == 2'h3) ? 32 : 16 + 4 * int'(r.wlen);
      m  = ~(32'hFFFF_FFFF >> wl);
      if (int'(r.off) + sl * (int'(s) + 1) > sl * int'(r.nsl)) begin
         return 32'h0;
      end
      return r.just ? ((slotv(int'(s)) << (sl - wl)) & m) : (slotv(int'(s)) & m);
   endfunction

   function automatic logic [31:0] expect_of(input row_s r);
      logic [31:0] a;
      logic [31:0] b;
      logic [32:0] sum;
      a = word_of((r.src == 2'h0) ? {1'h0, ADDR_STRAP} : r.sl, r);
      b = word_of(r.sr, r);
      sum = {a[31], a} + {b[31], b};
      return (r.src == 2'h3) ? sum[32:1] : ((r.src == 2'h2) ? b : a);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end
      else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge CORE_CLK);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      REG_ADDR  <= a;
      REG_WDATA <= d;
      REG_WR    <= 1'h1;
      @(posedge CORE_CLK);
      REG_WR    <= 1'h0;
      @(posedge CORE_CLK);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      REG_ADDR <= a;
      REG_RD   <= 1'h1;
      @(posedge CORE_CLK);
      REG_RD   <= 1'h0;
      #1;
      d = REG_RDATA;
      @(posedge CORE_CLK);
   endtask

   task automatic shape(input row_s r);
      frame_pol <= r.pol;
      rx_edge   <= r.edg;
      offset    <= r.off;
      slen_code <= r.slen;
      nslots    <= r.nsl;
   endtask

   // a frame change mid-flight spoils one frame, so the third sample is the one judged
   task automatic wait_frames(input int n);
      int c;
      int t;
      c = 0;
      t = 0;
      while (c < n && t < 5000) begin
         @(posedge CORE_CLK);
         t++;
         if (PLAYBACK_VALID === 1'h1) c++;
      end
      check(32'(c), 32'(n));
   endtask

   initial begin
      CORE_CLK = 1'h0;
      forever #50 CORE_CLK = ~CORE_CLK;
   end

   initial begin
      #6_000_000;
      miscompares++;
      $display("ERROR %0t: watchdog expired", $time);
      complete_run();
   end

   initial begin
      RESETN     = 1'h0;
      ADDR_STRAP = 3'h1;
      REG_ADDR   = 8'h00;
      REG_WDATA  = 32'h0;
      REG_WR     = 1'h0;
      REG_RD     = 1'h0;
      for (int i = 0; i < 16; i++) slots[i] = slotv(i);
      idle(16);
      check({REG_RDATA[0], PLAYBACK_VALID, CLOCK_FAULT}, 32'h1);
      RESETN <= 1'h1;
      @(posedge CORE_CLK);
      rd(`CFG_ADDR, got);
      check({28'h0, got[12:9]}, 32'hA);
      rd(8'h0C, got);
      check(got, 32'h0);
      wr(`CFG_ADDR, 32'hFFFF_FFFF);
      rd(`CFG_ADDR, got);
      check(got, 32'h3FFF_FFFF);
      foreach (rows[i]) begin
         shape(rows[i]);
         wr(`CFG_ADDR, cfg(rows[i], 1'h0, 3'h0, 4'h0));
         wait_frames(3);
         rd(`SAMPLE_ADDR, got);
         check(got, expect_of(rows[i]));
      end
      // no supported sample rate at 800 ns bit clocks
      check({31'h0, CLOCK_FAULT}, 32'h1);
      half_ns <= 16'h0145;
      shape(fast_r);
      wr(`CFG_ADDR, cfg(fast_r, 1'h0, 3'h0, 4'h0));
      idle(5000);
      rd(`STATUS_ADDR, got);
      check(got, {11'h0, 8'hFF, 1'h0, 5'h02, 4'h2, 3'h1});
      wr(`CFG_ADDR, cfg(fast_r, 1'h1, 3'h0, 4'h2));
      idle(100);
      check({31'h0, CLOCK_FAULT}, 32'h1);
      rd(`STATUS_ADDR, got);
      check({31'h0, got[20:13] != 8'h00 && got[20:13] != 8'hFF}, 32'h1);
      idle(5000);
      rd(`STATUS_ADDR, got);
      check({23'h0, got[20:12]}, 32'h1);
      check(PLAYBACK_SAMPLE, 32'h0);
      wr(`CFG_ADDR, cfg(fast_r, 1'h1, 3'h1, 4'h2));
      idle(5000);
      rd(`STATUS_ADDR, got);
      check({23'h0, got[20:12]}, 32'h1FE);
      // three 24-bit slots make 72 bit clocks a frame: no supported ratio
      half_ns   <= 16'h00FA;
      slen_code <= 2'h1;
      nslots    <= 5'h03;
      idle(2000);
      rd(`STATUS_ADDR, got);
      check({27'h0, got[12], got[6:3]}, 32'h1F);
      // a second reset retakes the strap, which moves the default playback slot
      half_ns    <= 16'h0190;
      ADDR_STRAP <= 3'h2;
      RESETN     <= 1'h0;
      idle(4);
      RESETN     <= 1'h1;
      idle(8);
      shape(rows[0]);
      wr(`CFG_ADDR, cfg(rows[0], 1'h0, 3'h0, 4'h0));
      wait_frames(3);
      rd(`SAMPLE_ADDR, got);
      check(got, expect_of(rows[0]));
      complete_run();
   end
endmodule // tdm_audio_receive_port_bench
